// ==== bench/wsm_chk.sv ====
// concurrent checks on the pin link between host and module
`timescale 1ns/1ps
`default_nettype none
module wsm_chk
  import wsm_pkg::*;
#(
  parameter int SLOW_HALF_CYC = 50,
  parameter int FAST_HALF_CYC = 5
) (
  input wire logic I_REF_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_CONNECTED,
  input wire logic I_CMD_MODE,
  input wire logic I_DISCOVERABLE,
  input wire logic I_HCI_MODE,
  input wire logic I_USB_MODE,
  input wire logic rst_n,
  input wire logic status_blink_pin,
  input wire logic link_up_pin,
  input wire logic h2d_txd,
  input wire logic d2h_txd,
  input wire logic rts,
  input wire logic cts,
  input wire logic usb_attach
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  localparam int FRM = 10 * BIT_CYC;
  logic in_rst;
  logic blk_q;
  logic usb_q;
  logic [2:0] md_q;
  logic [11:0] run_q;
  logic [11:0] mst_q;
  logic [1:0] txd;
  logic [1:0] txd_q;
  int el_q [2];
  assign in_rst = I_SYS_RST || !rst_n;
  assign txd = {h2d_txd, d2h_txd};
  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (in_rst);
  // mode age counter, so half periods are judged only well inside a mode
  always_ff @(posedge I_REF_CLK) begin
    md_q <= {I_CONNECTED, I_CMD_MODE, I_DISCOVERABLE};
    usb_q <= I_HCI_MODE && I_USB_MODE;
    if (in_rst || md_q != {I_CONNECTED, I_CMD_MODE, I_DISCOVERABLE}) begin
      mst_q <= 12'h000;
    end else if (mst_q != 12'hFFF) begin
      mst_q <= mst_q + 12'h001;
    end
  end
  always_ff @(posedge I_REF_CLK) begin
    blk_q <= status_blink_pin;
    if (status_blink_pin != blk_q) begin
      run_q <= 12'h001;
    end else if (run_q != 12'hFFF) begin
      run_q <= run_q + 12'h001;
    end
  end
  // frame position per direction, 0 while the line is idle
  always_ff @(posedge I_REF_CLK) begin
    txd_q <= txd;
    for (int i = 0; i < 2; i++) begin
      el_q[i] <= (in_rst || el_q[i] == FRM - 1) ? 0 :
        (el_q[i] != 0 || (txd_q[i] && !txd[i])) ? el_q[i] + 1 : 0;
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_link_follows_conn: assert property (
    !$past(in_rst) |-> link_up_pin == md_q[2])
    else $error("link pin not following connection");
  a_blink_steady_high: assert property (
    !$past(in_rst) && md_q[2] |-> status_blink_pin)
    else $error("status pin not high while connected");
  a_blink_idle_low: assert property (
    !$past(in_rst) && md_q == 3'b000 |-> !status_blink_pin)
    else $error("status pin active with no state");
  a_fast_half_period: assert property (
    I_CMD_MODE && !I_CONNECTED && mst_q > 3 * FAST_HALF_CYC &&
    status_blink_pin != blk_q |-> run_q == FAST_HALF_CYC)
    else $error("command state toggle period wrong");
  a_slow_half_period: assert property (
    !I_CMD_MODE && I_DISCOVERABLE && !I_CONNECTED &&
    mst_q > 3 * SLOW_HALF_CYC && status_blink_pin != blk_q
    |-> run_q == SLOW_HALF_CYC)
    else $error("discoverable toggle period wrong");
  a_usb_presence: assert property (
    !$past(in_rst) |-> usb_attach == usb_q)
    else $error("usb presence not matching mode");
  a_bit_width_both: assert property (
    (el_q[0] != 0 && txd[0] != txd_q[0] |-> el_q[0] % BIT_CYC == 0) and
    (el_q[1] != 0 && txd[1] != txd_q[1] |-> el_q[1] % BIT_CYC == 0))
    else $error("serial bit edge off the bit grid");
  a_stop_bit_high: assert property (
    el_q[0] == FRM - 1 || el_q[1] == FRM - 1 |->
    (el_q[0] != FRM - 1 || d2h_txd) && (el_q[1] != FRM - 1 || h2d_txd))
    else $error("stop bit not high");
  a_dev_obeys_cts: assert property (
    el_q[0] == 0 && txd_q[0] && !d2h_txd |-> !$past(cts))
    else $error("module started a byte while stopped");
  a_host_obeys_rts: assert property (
    el_q[1] == 0 && txd_q[1] && !h2d_txd |-> !$past(rts))
    else $error("host started a byte while stopped");
endmodule : wsm_chk
`default_nettype wire

// ==== bench/wsm_tb_top.sv ====
// self-checking bench for both ends of the module link
`timescale 1ns/1ps
`default_nettype none
module wsm_tb_top;
  import wsm_pkg::*;
  // ----------------------------------------------------------------
  // wiring
  // ----------------------------------------------------------------
  localparam int SLOW = 50;
  localparam int FAST = 5;
  localparam int WIN = 1000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic conn, disc, cmd, hci, usb, cfg_we, d_tv, d_tr, d_hold, d_rh, d_rc;
  logic req, sent, h_tv, h_tr, h_hold, h_rv, h_conn, h_blink, h_usb;
  logic restored, rest2, sent_seen, in_rst1, in_rst2, d2_tr;
  logic [7:0] cfg_wd, cfg, d_td, d_rd, h_td, h_rd;
  int error_cnt = 0;
  int comparisons = 0;
  wsm_if lnk();
  wsm_if lnk2();
  always #10 clk = ~clk;
  always @(posedge clk) sent_seen <= !rst && (sent_seen || sent === 1'b1);
  wsm_dev #(.DEB_CYC(8), .GAP_CYC(200), .ABORT_CYC(1000),
    .SLOW_HALF_CYC(SLOW), .FAST_HALF_CYC(FAST)) i_wsm_dev (
    .I_REF_CLK(clk), .I_SYS_RST(rst), .LNK(lnk.dev), .I_CONNECTED(conn),
    .I_DISCOVERABLE(disc), .I_CMD_MODE(cmd), .I_HCI_MODE(hci),
    .I_USB_MODE(usb), .I_CFG_WE(cfg_we), .I_CFG_WDATA(cfg_wd), .O_CFG(cfg),
    .O_DEFAULTS_RESTORED(restored), .I_TX_DATA(d_td), .I_TX_VALID(d_tv),
    .O_TX_READY(d_tr), .I_RX_HOLD(d_hold), .O_RX_DATA(d_rd),
    .O_RX_HCI_VALID(d_rh), .O_RX_CMD_VALID(d_rc), .O_IN_RESET(in_rst1));
  // second module end, driven directly to break the request sequence
  wsm_dev #(.DEB_CYC(8), .GAP_CYC(200), .ABORT_CYC(1000),
    .SLOW_HALF_CYC(SLOW), .FAST_HALF_CYC(FAST)) i_wsm_dev_2 (
    .I_REF_CLK(clk), .I_SYS_RST(rst), .LNK(lnk2.dev), .I_CONNECTED(conn),
    .I_DISCOVERABLE(disc), .I_CMD_MODE(cmd), .I_HCI_MODE(hci),
    .I_USB_MODE(usb), .I_CFG_WE(cfg_we), .I_CFG_WDATA(cfg_wd), .O_CFG(),
    .O_DEFAULTS_RESTORED(rest2), .I_TX_DATA(d_td), .I_TX_VALID(d_tv),
    .O_TX_READY(d2_tr), .I_RX_HOLD(d_hold), .O_RX_DATA(),
    .O_RX_HCI_VALID(), .O_RX_CMD_VALID(), .O_IN_RESET(in_rst2));
  wsm_host #(.GAP_CYC(200), .PULSE_CYC(40)) i_wsm_host (
    .I_REF_CLK(clk), .I_SYS_RST(rst), .LNK(lnk.host), .I_REQ_DEFAULTS(req),
    .O_DEFAULTS_SENT(sent), .I_TX_DATA(h_td), .I_TX_VALID(h_tv),
    .O_TX_READY(h_tr), .I_RX_HOLD(h_hold), .O_RX_DATA(h_rd),
    .O_RX_VALID(h_rv), .O_CONNECTED(h_conn), .O_STATUS_BLINK(h_blink),
    .O_USB_ATTACHED(h_usb));
  wsm_chk #(.SLOW_HALF_CYC(SLOW), .FAST_HALF_CYC(FAST)) i_wsm_chk (
    .I_REF_CLK(clk), .I_SYS_RST(rst), .I_CONNECTED(conn), .I_CMD_MODE(cmd),
    .I_DISCOVERABLE(disc), .I_HCI_MODE(hci), .I_USB_MODE(usb),
    .rst_n(lnk.rst_n), .status_blink_pin(lnk.status_blink_pin),
    .link_up_pin(lnk.link_up_pin), .h2d_txd(lnk.h2d_txd),
    .d2h_txd(lnk.d2h_txd), .rts(lnk.rts), .cts(lnk.cts),
    .usb_attach(lnk.usb_attach));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic cmp(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask : cmp
  task automatic report_and_stop();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // restore through the host walk, or a plain start-up when r is low
  task automatic t_defaults(input logic r);
    int n;
    @(posedge clk);
    rst <= 1'b1;
    req <= r;
    tick(3);
    rst <= 1'b0;
    tick(2);
    cmp("module held in reset", 1'b1, in_rst1);
    n = 0;
    while (lnk.rst_n !== 1'b1 && n < 2000) begin
      tick(1);
      n++;
    end
    cmp("module out of reset", 1'b0, in_rst1);
    cfg_we <= 1'b1;
    cfg_wd <= 8'h3C;
    tick(1);
    cfg_we <= 1'b0;
    tick(2);
    cmp("stored config", 8'h3C, cfg);
    n = 0;
    while (restored !== 1'b1 && n < 3000) begin
      tick(1);
      n++;
    end
    cmp("restore pulse", r, restored);
    tick(2);
    cmp("config after", r ? CFG_DEFAULT : 8'h3C, cfg);
    cmp("request sent", r, sent_seen);
  endtask : t_defaults
  // second end: rises are gap+40 cycles apart
  task automatic t_abort(input int gap, input logic exp);
    int n;
    lnk2.rst_n <= 1'b0;
    lnk2.defaults_request_pin <= 1'b1;
    tick(20);
    cmp("second end in reset", 1'b1, in_rst2);
    lnk2.rst_n <= 1'b1;
    tick(40);
    lnk2.defaults_request_pin <= 1'b0;
    tick(40);
    lnk2.defaults_request_pin <= 1'b1;
    tick(gap);
    lnk2.defaults_request_pin <= 1'b0;
    tick(40);
    lnk2.defaults_request_pin <= 1'b1;
    n = 0;
    while (rest2 !== 1'b1 && n < 300) begin
      tick(1);
      n++;
    end
    cmp("restore second end", exp, rest2);
    cmp("second end ready", 1'b0, d2_tr);
  endtask : t_abort
  task automatic t_status();
    logic [2:0] md [5] = '{3'b000, 3'b001, 3'b010, 3'b011, 3'b100};
    int n;
    int e;
    int h;
    logic p;
    for (int k = 0; k < 5; k++) begin
      {conn, cmd, disc} <= md[k];
      tick(200);
      n = 0;
      h = 0;
      for (int j = 0; j < WIN; j++) begin
        p = h_blink;
        h += (p === 1'b1);
        tick(1);
        n += (h_blink !== p);
      end
      e = md[k][2] ? 0 : md[k][1] ? WIN / FAST : md[k][0] ? WIN / SLOW : 0;
      cmp("blink toggles", e, n);
      cmp("connected level", md[k][2], h_conn);
      cmp("blink high time", md[k][2] ? WIN : e != 0 ? WIN / 2 : 0, h);
    end
    hci <= 1'b1;
    usb <= 1'b1;
    tick(5);
    cmp("usb attach", 1'b1, h_usb);
    usb <= 1'b0;
    tick(5);
    cmp("usb detach", 1'b0, h_usb);
  endtask : t_status
  // one byte, the far side stopping the sender first when hold is set
  task automatic t_xfer(input bit d2h, input logic [7:0] b, input bit hold,
                        input logic h);
    int n;
    hci <= h;
    if (d2h) h_hold <= hold;
    else d_hold <= hold;
    tick(4);
    d_td <= b;
    h_td <= b;
    d_tv <= d2h;
    h_tv <= !d2h;
    n = 0;
    for (int j = 0; j < 100 && hold; j++) begin
      tick(1);
      n += ((d2h ? d_tr : h_tr) === 1'b1);
    end
    cmp("ready while stopped", 0, n);
    h_hold <= 1'b0;
    d_hold <= 1'b0;
    tick(1);
    n = 0;
    while ((d2h ? d_tr : h_tr) !== 1'b1 && n < 5000) begin
      tick(1);
      n++;
    end
    d_tv <= 1'b0;
    h_tv <= 1'b0;
    n = 0;
    while ((d2h ? h_rv : (d_rh | d_rc)) !== 1'b1 && n < 6000) begin
      tick(1);
      n++;
    end
    cmp("receive valid", 1'b1, d2h ? h_rv : (d_rh | d_rc));
    cmp("received byte", b, d2h ? h_rd : d_rd);
    if (!d2h) cmp("hci route", h, d_rh);
  endtask : t_xfer
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    {conn, disc, cmd, hci, usb, cfg_we, d_tv, d_hold, h_tv, h_hold} = '0;
    {cfg_wd, d_td, h_td} = '0;
    req = 1'b1;
    lnk2.rst_n = 1'b0;
    lnk2.defaults_request_pin = 1'b0;
    lnk2.h2d_txd = 1'b1;
    lnk2.cts = 1'b1;
    t_defaults(1'b1);
    t_defaults(1'b0);
    t_abort(100, 1'b0);
    t_abort(1100, 1'b0);
    t_abort(300, 1'b1);
    t_status();
    t_xfer(1'b0, 8'hA5, 1'b0, 1'b1);
    t_xfer(1'b0, 8'h3C, 1'b1, 1'b0);
    t_xfer(1'b1, 8'h5A, 1'b0, 1'b1);
    t_xfer(1'b1, 8'hC3, 1'b1, 1'b1);
    report_and_stop();
  end
  // about 30k cycles expected, so this only trips on a hang
  initial begin
    tick(100000);
    error_cnt++;
    report_and_stop();
  end
endmodule : wsm_tb_top
`default_nettype wire

// ==== common/wsm_if.sv ====
// pin-level link between the host and the module
`timescale 1ns/1ps
`default_nettype none
interface wsm_if;
  logic rst_n;
  logic defaults_request_pin;
  logic status_blink_pin;
  logic link_up_pin;
  logic h2d_txd;
  logic d2h_txd;
  logic rts;
  logic cts;
  logic usb_attach;
  modport dev (
    input rst_n, defaults_request_pin, h2d_txd, cts,
    output status_blink_pin, link_up_pin, d2h_txd, rts, usb_attach
  );
  modport host (
    output rst_n, defaults_request_pin, h2d_txd, cts,
    input status_blink_pin, link_up_pin, d2h_txd, rts, usb_attach
  );
endinterface : wsm_if
`default_nettype wire

// ==== common/wsm_pkg.sv ====
// constants and types shared by both ends of the module link
package wsm_pkg;
  // ----------------------------------------------------------------
  // clock and time
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int CNT_W = 28;
  localparam int DEF_GAP_S = 1;
  localparam int DEF_GAP_CYC = CLK_HZ * DEF_GAP_S;
  localparam int SLOW_BLINK_HZ = 1;
  localparam int FAST_BLINK_HZ = 10;
  localparam int SLOW_HALF_CYC = CLK_HZ / (2 * SLOW_BLINK_HZ);
  localparam int FAST_HALF_CYC = CLK_HZ / (2 * FAST_BLINK_HZ);
  localparam int DEB_MS = 10;
  localparam int DEB_CYC = (CLK_HZ / 1000) * DEB_MS;
  localparam int ABORT_S = 5;
  localparam int ABORT_CYC = CLK_HZ * ABORT_S;
  localparam int PULSE_MS = 100;
  localparam int PULSE_CYC = (CLK_HZ / 1000) * PULSE_MS;
  localparam int RST_HOLD_US = 10;
  localparam int RST_HOLD_CYC = (CLK_HZ / 1_000_000) * RST_HOLD_US;
  // ----------------------------------------------------------------
  // serial link
  // ----------------------------------------------------------------
  localparam int UART_BPS = 115_200;
  localparam int BIT_CYC = CLK_HZ / UART_BPS;
  localparam int BIT_W = 9;
  localparam int CFG_W = 8;
  localparam logic [7:0] CFG_DEFAULT = 8'h00;
  // ----------------------------------------------------------------
  // state types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    FR_ARM = 3'b000,
    FR_FALL1 = 3'b001,
    FR_RISE1 = 3'b010,
    FR_FALL2 = 3'b011,
    FR_RISE2 = 3'b100,
    FR_IDLE = 3'b101
  } wsm_fr_state_t;
  typedef enum logic [2:0] {
    HS_PWR = 3'b000,
    HS_SETTLE = 3'b001,
    HS_LOW1 = 3'b010,
    HS_HIGH1 = 3'b011,
    HS_LOW2 = 3'b100,
    HS_DONE = 3'b101
  } wsm_hs_state_t;
endpackage : wsm_pkg

// ==== rtl/wsm_dev.sv ====
// module end: status pins, defaults restore, flow-controlled serial
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------------
// serial transmitter, 8N1
// ------------------------------------------------------------------
module wsm_uart_tx #(
  parameter int BIT_CYC = wsm_pkg::BIT_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_data,
  input wire logic i_valid,
  input wire logic i_hold,
  output logic o_ready,
  output logic o_txd
);
  import wsm_pkg::*;
  logic [9:0] sh_q;
  logic [3:0] nbit_q;
  logic [BIT_W-1:0] cnt_q;
  logic busy_q;
  // hold is checked only between bytes, a started frame always ends
  assign o_ready = !busy_q && !i_hold;
  assign o_txd = busy_q ? sh_q[0] : 1'b1;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      busy_q <= 1'b0;
      sh_q <= 10'h3FF;
      nbit_q <= 4'h0;
      cnt_q <= '0;
    end else if (!busy_q) begin
      if (i_valid && o_ready) begin
        busy_q <= 1'b1;
        sh_q <= {1'b1, i_data, 1'b0};
        nbit_q <= 4'h0;
        cnt_q <= '0;
      end
    end else if (cnt_q == BIT_W'(BIT_CYC - 1)) begin
      cnt_q <= '0;
      sh_q <= {1'b1, sh_q[9:1]};
      nbit_q <= nbit_q + 4'h1;
      if (nbit_q == 4'h9) begin
        busy_q <= 1'b0;
      end
    end else begin
      cnt_q <= cnt_q + BIT_W'(1);
    end
  end
endmodule : wsm_uart_tx
// ------------------------------------------------------------------
// module end top
// ------------------------------------------------------------------
module wsm_dev #(
  parameter int DEB_CYC = wsm_pkg::DEB_CYC,
  parameter int GAP_CYC = wsm_pkg::DEF_GAP_CYC,
  parameter int ABORT_CYC = wsm_pkg::ABORT_CYC,
  parameter int SLOW_HALF_CYC = wsm_pkg::SLOW_HALF_CYC,
  parameter int FAST_HALF_CYC = wsm_pkg::FAST_HALF_CYC
) (
  input wire logic I_REF_CLK,
  input wire logic I_SYS_RST,
  wsm_if.dev LNK,
  input wire logic I_CONNECTED,
  input wire logic I_DISCOVERABLE,
  input wire logic I_CMD_MODE,
  input wire logic I_HCI_MODE,
  input wire logic I_USB_MODE,
  input wire logic I_CFG_WE,
  input wire logic [wsm_pkg::CFG_W-1:0] I_CFG_WDATA,
  output logic [wsm_pkg::CFG_W-1:0] O_CFG,
  output logic O_DEFAULTS_RESTORED,
  input wire logic [7:0] I_TX_DATA,
  input wire logic I_TX_VALID,
  output logic O_TX_READY,
  input wire logic I_RX_HOLD,
  output logic [7:0] O_RX_DATA,
  output logic O_RX_HCI_VALID,
  output logic O_RX_CMD_VALID,
  output logic O_IN_RESET
);
  import wsm_pkg::*;
  logic rst;
  logic deb_q;
  logic [CNT_W-1:0] deb_cnt_q;
  logic [CNT_W-1:0] t_q;
  logic [CNT_W-1:0] gap_q;
  logic deb_prev_q;
  logic rise;
  logic fall;
  wsm_fr_state_t fr_q;
  logic [CNT_W-1:0] blink_cnt_q;
  logic blink_q;
  logic [CNT_W-1:0] half;
  logic rx_valid;
  // either reset source puts the whole end in reset
  assign rst = I_SYS_RST || !LNK.rst_n;
  assign O_IN_RESET = rst;
  // ----------------------------------------------------------------
  // request pin debounce and sequence detector
  // ----------------------------------------------------------------
  always_ff @(posedge I_REF_CLK) begin
    if (rst) begin
      deb_q <= 1'b0;
      deb_cnt_q <= '0;
      deb_prev_q <= 1'b0;
    end else begin
      deb_prev_q <= deb_q;
      if (LNK.defaults_request_pin == deb_q) begin
        deb_cnt_q <= '0;
      end else if (deb_cnt_q == CNT_W'(DEB_CYC - 1)) begin
        deb_cnt_q <= '0;
        deb_q <= LNK.defaults_request_pin;
      end else begin
        deb_cnt_q <= deb_cnt_q + CNT_W'(1);
      end
    end
  end
  assign rise = deb_q && !deb_prev_q;
  assign fall = !deb_q && deb_prev_q;
  always_ff @(posedge I_REF_CLK) begin
    if (rst) begin
      fr_q <= FR_ARM;
      t_q <= '0;
      gap_q <= '0;
      O_DEFAULTS_RESTORED <= 1'b0;
    end else begin
      O_DEFAULTS_RESTORED <= 1'b0;
      t_q <= t_q + CNT_W'(1);
      gap_q <= gap_q + CNT_W'(1);
      case (fr_q)
        FR_ARM: begin
          // pin must already be high once debounce has settled
          if (t_q == CNT_W'(2 * DEB_CYC)) begin
            fr_q <= deb_q ? FR_FALL1 : FR_IDLE;
            t_q <= '0;
          end
        end
        FR_FALL1, FR_FALL2: begin
          if (t_q == CNT_W'(ABORT_CYC)) begin
            fr_q <= FR_IDLE;
          end else if (fall) begin
            fr_q <= (fr_q == FR_FALL1) ? FR_RISE1 : FR_RISE2;
            t_q <= '0;
          end
        end
        FR_RISE1: begin
          if (t_q == CNT_W'(ABORT_CYC)) begin
            fr_q <= FR_IDLE;
          end else if (rise) begin
            fr_q <= FR_FALL2;
            t_q <= '0;
            gap_q <= '0;
          end
        end
        FR_RISE2: begin
          if (t_q == CNT_W'(ABORT_CYC)) begin
            fr_q <= FR_IDLE;
          end else if (rise) begin
            fr_q <= FR_IDLE;
            // too early a second rise is a deviation, not a request
            O_DEFAULTS_RESTORED <= (gap_q >= CNT_W'(GAP_CYC));
          end
        end
        default: begin
          fr_q <= FR_IDLE;
        end
      endcase
    end
  end
  // restore beats a software write in the same cycle
  always_ff @(posedge I_REF_CLK) begin
    if (rst) begin
      O_CFG <= CFG_DEFAULT;
    end else if (O_DEFAULTS_RESTORED) begin
      O_CFG <= CFG_DEFAULT;
    end else if (I_CFG_WE) begin
      O_CFG <= I_CFG_WDATA;
    end
  end
  // ----------------------------------------------------------------
  // status pins
  // ----------------------------------------------------------------
  assign half = I_CMD_MODE ? CNT_W'(FAST_HALF_CYC)
                           : CNT_W'(SLOW_HALF_CYC);
  always_ff @(posedge I_REF_CLK) begin
    if (rst) begin
      blink_cnt_q <= '0;
      blink_q <= 1'b0;
    end else if (blink_cnt_q >= half - CNT_W'(1)) begin
      blink_cnt_q <= '0;
      blink_q <= !blink_q;
    end else begin
      blink_cnt_q <= blink_cnt_q + CNT_W'(1);
    end
  end
  always_ff @(posedge I_REF_CLK) begin
    if (rst) begin
      LNK.status_blink_pin <= 1'b0;
      LNK.link_up_pin <= 1'b0;
      LNK.usb_attach <= 1'b0;
    end else begin
      LNK.link_up_pin <= I_CONNECTED;
      if (I_CONNECTED) begin
        LNK.status_blink_pin <= 1'b1;
      end else if (I_CMD_MODE || I_DISCOVERABLE) begin
        LNK.status_blink_pin <= blink_q;
      end else begin
        LNK.status_blink_pin <= 1'b0;
      end
      LNK.usb_attach <= I_HCI_MODE && I_USB_MODE;
    end
  end
  // ----------------------------------------------------------------
  // serial link with flow control
  // ----------------------------------------------------------------
  always_ff @(posedge I_REF_CLK) begin
    if (rst) begin
      LNK.rts <= 1'b1;
    end else begin
      LNK.rts <= I_RX_HOLD;
    end
  end
  wsm_uart_tx #(.BIT_CYC(BIT_CYC)) u_tx (
    .i_clk(I_REF_CLK),
    .i_rst(rst),
    .i_data(I_TX_DATA),
    .i_valid(I_TX_VALID),
    .i_hold(LNK.cts),
    .o_ready(O_TX_READY),
    .o_txd(LNK.d2h_txd)
  );
  wsm_uart_rx #(.BIT_CYC(BIT_CYC)) u_rx (
    .i_clk(I_REF_CLK),
    .i_rst(rst),
    .i_rxd(LNK.h2d_txd),
    .o_data(O_RX_DATA),
    .o_valid(rx_valid)
  );
  // controller mode hands bytes straight to the host-side stack
  assign O_RX_HCI_VALID = rx_valid && I_HCI_MODE;
  assign O_RX_CMD_VALID = rx_valid && !I_HCI_MODE;
endmodule : wsm_dev
`default_nettype wire

// ==== rtl/wsm_host.sv ====
// host end: module reset, defaults request, serial link, status
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------------
// serial receiver, 8N1, mid-bit sampling
// ------------------------------------------------------------------
module wsm_uart_rx #(
  parameter int BIT_CYC = wsm_pkg::BIT_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_rxd,
  output logic [7:0] o_data,
  output logic o_valid
);
  import wsm_pkg::*;
  logic [7:0] sh_q;
  logic [3:0] nbit_q;
  logic [BIT_W-1:0] cnt_q;
  logic busy_q;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      busy_q <= 1'b0;
      sh_q <= 8'h00;
      nbit_q <= 4'h0;
      cnt_q <= '0;
      o_data <= 8'h00;
      o_valid <= 1'b0;
    end else begin
      o_valid <= 1'b0;
      if (!busy_q) begin
        if (!i_rxd) begin
          busy_q <= 1'b1;
          nbit_q <= 4'h0;
          cnt_q <= BIT_W'(BIT_CYC / 2);
        end
      end else if (cnt_q == BIT_W'(BIT_CYC - 1)) begin
        cnt_q <= '0;
        nbit_q <= nbit_q + 4'h1;
        if (nbit_q == 4'h0 && i_rxd) begin
          busy_q <= 1'b0; // glitch, not a start bit
        end else if (nbit_q == 4'h9) begin
          busy_q <= 1'b0;
          o_valid <= i_rxd; // framing error drops the byte
          o_data <= sh_q;
        end else if (nbit_q != 4'h0) begin
          sh_q <= {i_rxd, sh_q[7:1]};
        end
      end else begin
        cnt_q <= cnt_q + BIT_W'(1);
      end
    end
  end
endmodule : wsm_uart_rx
// ------------------------------------------------------------------
// host end top
// ------------------------------------------------------------------
module wsm_host #(
  parameter int GAP_CYC = wsm_pkg::DEF_GAP_CYC,
  parameter int PULSE_CYC = wsm_pkg::PULSE_CYC
) (
  input wire logic I_REF_CLK,
  input wire logic I_SYS_RST,
  wsm_if.host LNK,
  input wire logic I_REQ_DEFAULTS,
  output logic O_DEFAULTS_SENT,
  input wire logic [7:0] I_TX_DATA,
  input wire logic I_TX_VALID,
  output logic O_TX_READY,
  input wire logic I_RX_HOLD,
  output logic [7:0] O_RX_DATA,
  output logic O_RX_VALID,
  output logic O_CONNECTED,
  output logic O_STATUS_BLINK,
  output logic O_USB_ATTACHED
);
  import wsm_pkg::*;
  wsm_hs_state_t hs_q;
  logic [CNT_W-1:0] t_q;
  logic req_q;
  // ----------------------------------------------------------------
  // module reset and defaults request sequence
  // ----------------------------------------------------------------
  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      hs_q <= HS_PWR;
      t_q <= '0;
      req_q <= 1'b0;
      LNK.rst_n <= 1'b0;
      LNK.defaults_request_pin <= 1'b0;
      O_DEFAULTS_SENT <= 1'b0;
    end else begin
      t_q <= t_q + CNT_W'(1);
      case (hs_q)
        HS_PWR: begin
          // request level is caught while the module is held in reset
          req_q <= I_REQ_DEFAULTS;
          LNK.defaults_request_pin <= I_REQ_DEFAULTS;
          if (t_q == CNT_W'(RST_HOLD_CYC - 1)) begin
            LNK.rst_n <= 1'b1;
            hs_q <= req_q ? HS_SETTLE : HS_DONE;
            t_q <= '0;
          end
        end
        HS_SETTLE: begin
          if (t_q == CNT_W'(PULSE_CYC - 1)) begin
            LNK.defaults_request_pin <= 1'b0;
            hs_q <= HS_LOW1;
            t_q <= '0;
          end
        end
        HS_LOW1, HS_LOW2: begin
          if (t_q == CNT_W'(PULSE_CYC - 1)) begin
            LNK.defaults_request_pin <= 1'b1;
            O_DEFAULTS_SENT <= (hs_q == HS_LOW2);
            hs_q <= (hs_q == HS_LOW1) ? HS_HIGH1 : HS_DONE;
            t_q <= '0;
          end
        end
        HS_HIGH1: begin
          // the low pulse adds to this wait, so the gap is never short
          if (t_q == CNT_W'(GAP_CYC - 1)) begin
            LNK.defaults_request_pin <= 1'b0;
            hs_q <= HS_LOW2;
            t_q <= '0;
          end
        end
        default: begin
          hs_q <= HS_DONE;
          t_q <= '0;
          O_DEFAULTS_SENT <= 1'b0;
        end
      endcase
    end
  end
  // ----------------------------------------------------------------
  // serial link and status
  // ----------------------------------------------------------------
  always_ff @(posedge I_REF_CLK) begin
    if (I_SYS_RST) begin
      LNK.cts <= 1'b1;
      O_CONNECTED <= 1'b0;
      O_STATUS_BLINK <= 1'b0;
      O_USB_ATTACHED <= 1'b0;
    end else begin
      LNK.cts <= I_RX_HOLD;
      O_CONNECTED <= LNK.link_up_pin;
      O_STATUS_BLINK <= LNK.status_blink_pin;
      O_USB_ATTACHED <= LNK.usb_attach;
    end
  end
  wsm_uart_tx #(.BIT_CYC(BIT_CYC)) u_tx (
    .i_clk(I_REF_CLK),
    .i_rst(I_SYS_RST),
    .i_data(I_TX_DATA),
    .i_valid(I_TX_VALID),
    .i_hold(LNK.rts || !LNK.rst_n),
    .o_ready(O_TX_READY),
    .o_txd(LNK.h2d_txd)
  );
  wsm_uart_rx #(.BIT_CYC(BIT_CYC)) u_rx (
    .i_clk(I_REF_CLK),
    .i_rst(I_SYS_RST),
    .i_rxd(LNK.d2h_txd),
    .o_data(O_RX_DATA),
    .o_valid(O_RX_VALID)
  );
endmodule : wsm_host
`default_nettype wire
